// ==== ocs_ovr_stretch.sv ====
// shared constants for the over-range and clock-out block, plus the per-channel pulse stretcher
// assumes sample magnitudes arrive synchronous to clk_sys, one per cycle
package ocs_pkg;
   localparam int OCS_MAG_W = 9;
   localparam int OCS_LEN_W = 8;
   localparam int OCS_NUM_CH = 4;
   localparam int OCS_CH_DUAL = 2;
   localparam int OCS_CH_QUAD = 4;
   localparam logic [1:0] OCS_SEL_OFF = 2'h0;
   localparam logic [1:0] OCS_SEL_DIV1 = 2'h1;
   localparam logic [1:0] OCS_SEL_DIV2 = 2'h2;
   localparam logic [1:0] OCS_SEL_DIV4 = 2'h3;
   localparam logic OCS_RST_LOW = 1'b0;
endpackage

`timescale 1ns/10ps
`default_nettype none

module ocs_ovr_stretch
#(
   parameter int MAG_W = ocs_pkg::OCS_MAG_W,
   parameter int LEN_W = ocs_pkg::OCS_LEN_W
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic enable,
   input wire logic [MAG_W-1:0] magnitude,
   input wire logic [MAG_W-1:0] threshold,
   input wire logic [LEN_W-1:0] min_len,
   output logic flag
);
   import ocs_pkg::*;

   localparam logic [LEN_W-1:0] ONE = LEN_W'(1);
   localparam logic [LEN_W-1:0] ZERO = LEN_W'(0);

   logic [LEN_W-1:0] cnt_q;
   logic [LEN_W-1:0] cnt_d;
   logic flag_q;
   logic flag_d;
   logic over;

   // =========================================
   // detect and stretch
   always_comb
   begin
      over = enable && (magnitude > threshold);
      flag_d = over || (cnt_q > ONE);
      if (over)
      begin
         cnt_d = min_len;
      end
      else if (cnt_q != ZERO)
      begin
         cnt_d = cnt_q - ONE;
      end
      else
      begin
         cnt_d = ZERO;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         cnt_q <= ZERO;
         flag_q <= OCS_RST_LOW;
      end
      else
      begin
         cnt_q <= cnt_d;
         flag_q <= flag_d;
      end
   end

   assign flag = flag_q;
endmodule

`default_nettype wire

// ==== ocs_top.sv ====
// over-range status outputs with channel C/D auxiliary reference-clock outputs
// assumes pll_ref_in is sampled as a synchronous level on clk_sys; its copies change on clk_sys edges
// What this block does
// - over-range output goes high while channel magnitude exceeds programmed threshold
// - once high, output stays high at least the programmed pulse length
// - channel B over-range works only in quad and dual variants
// - channel C over-range detection exists only in quad variant
// - channel C becomes clock output when selected by pins or override, PLL enabled
// - select zero or clock disabled makes channel C carry its over-range flag
// - select 1 copies reference, 2 divides by two, 3 divides by four
// - clock appears from reset with no register access when pins select it
// - channel D carries clock only while channel C carries clock
// - power-down stops reference output and both auxiliary clock outputs
`timescale 1ns/10ps
`default_nettype none

module ocs_top
#(
   parameter int NUM_CH = ocs_pkg::OCS_NUM_CH,
   parameter int MAG_W = ocs_pkg::OCS_MAG_W,
   parameter int LEN_W = ocs_pkg::OCS_LEN_W
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [MAG_W-1:0] magnitude_a,
   input wire logic [MAG_W-1:0] magnitude_b,
   input wire logic [MAG_W-1:0] magnitude_c,
   input wire logic [MAG_W-1:0] magnitude_d,
   input wire logic [MAG_W-1:0] over_range_threshold,
   input wire logic [LEN_W-1:0] over_range_min_pulse_len,
   input wire logic [1:0] aux_clock_select_pins,
   input wire logic clock_override_en,
   input wire logic [1:0] clock_override_sel_c,
   input wire logic [1:0] clock_override_sel_d,
   input wire logic clock_out_disable,
   input wire logic pll_enable_pin,
   input wire logic power_down_pin,
   input wire logic pll_ref_in,
   output logic over_range_out_a,
   output logic over_range_out_b,
   output logic over_range_or_clock_out_c,
   output logic over_range_or_clock_out_d,
   output logic pll_reference_clock_out
);
   import ocs_pkg::*;

   localparam logic EN_B = (NUM_CH >= OCS_CH_DUAL);
   localparam logic EN_QUAD = (NUM_CH == OCS_CH_QUAD);

   logic flag_a;
   logic flag_b;
   logic flag_c;
   logic flag_d;

   // =========================================
   // per-channel detectors
   ocs_ovr_stretch #(.MAG_W(MAG_W), .LEN_W(LEN_W)) u_ch_a
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .enable(1'b1),
      .magnitude(magnitude_a),
      .threshold(over_range_threshold),
      .min_len(over_range_min_pulse_len),
      .flag(flag_a)
   );

   ocs_ovr_stretch #(.MAG_W(MAG_W), .LEN_W(LEN_W)) u_ch_b
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .enable(EN_B),
      .magnitude(magnitude_b),
      .threshold(over_range_threshold),
      .min_len(over_range_min_pulse_len),
      .flag(flag_b)
   );

   ocs_ovr_stretch #(.MAG_W(MAG_W), .LEN_W(LEN_W)) u_ch_c
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .enable(EN_QUAD),
      .magnitude(magnitude_c),
      .threshold(over_range_threshold),
      .min_len(over_range_min_pulse_len),
      .flag(flag_c)
   );

   ocs_ovr_stretch #(.MAG_W(MAG_W), .LEN_W(LEN_W)) u_ch_d
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .enable(EN_QUAD),
      .magnitude(magnitude_d),
      .threshold(over_range_threshold),
      .min_len(over_range_min_pulse_len),
      .flag(flag_d)
   );

   // =========================================
   // reference dividers
   // they keep running in power-down so re-enabled clocks need no restart
   logic ref_prev_q;
   logic ref_prev_d;
   logic div2_q;
   logic div2_d;
   logic div4_q;
   logic div4_d;

   always_comb
   begin
      ref_prev_d = pll_ref_in;
      div2_d = div2_q;
      div4_d = div4_q;
      // the rising edge of the reference is seen in the same cycle that pll_ref_in first reads high
      if (pll_ref_in && !ref_prev_q)
      begin
         div2_d = !div2_q;
         if (!div2_q)
         begin
            div4_d = !div4_q;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         ref_prev_q <= OCS_RST_LOW;
         div2_q <= OCS_RST_LOW;
         div4_q <= OCS_RST_LOW;
      end
      else
      begin
         ref_prev_q <= ref_prev_d;
         div2_q <= div2_d;
         div4_q <= div4_d;
      end
   end

   // =========================================
   // clock source select
   logic [1:0] sel_c;
   logic [1:0] sel_d;
   logic clk_c_on;
   logic clk_c_val;
   logic clk_d_val;

   function automatic logic pick_clk(input logic [1:0] sel, input logic r, input logic d2, input logic d4);
      logic v;
      v = 1'b0;
      unique case (sel)
         OCS_SEL_OFF: v = 1'b0;
         OCS_SEL_DIV1: v = r;
         OCS_SEL_DIV2: v = d2;
         OCS_SEL_DIV4: v = d4;
      endcase
      return v;
   endfunction

   always_comb
   begin
      // pins act straight from reset; override only when software asks
      sel_c = clock_override_en ? clock_override_sel_c : aux_clock_select_pins;
      // without override channel D follows the reference as a plain copy
      sel_d = clock_override_en ? clock_override_sel_d : OCS_SEL_DIV1;
      clk_c_on = (sel_c != OCS_SEL_OFF) && !clock_out_disable && pll_enable_pin && !power_down_pin;
      clk_c_val = pick_clk(sel_c, pll_ref_in, div2_q, div4_q);
      clk_d_val = pick_clk(sel_d, pll_ref_in, div2_q, div4_q);
   end

   // =========================================
   // output registers
   logic out_a_q;
   logic out_a_d;
   logic out_b_q;
   logic out_b_d;
   logic out_c_q;
   logic out_c_d;
   logic out_d_q;
   logic out_d_d;
   logic ref_out_q;
   logic ref_out_d;

   always_comb
   begin
      out_a_d = flag_a;
      out_b_d = flag_b;
      out_c_d = clk_c_on ? clk_c_val : flag_c;
      out_d_d = clk_c_on ? clk_d_val : flag_d;
      ref_out_d = pll_enable_pin && !power_down_pin && pll_ref_in;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         out_a_q <= OCS_RST_LOW;
         out_b_q <= OCS_RST_LOW;
         out_c_q <= OCS_RST_LOW;
         out_d_q <= OCS_RST_LOW;
         ref_out_q <= OCS_RST_LOW;
      end
      else
      begin
         out_a_q <= out_a_d;
         out_b_q <= out_b_d;
         out_c_q <= out_c_d;
         out_d_q <= out_d_d;
         ref_out_q <= ref_out_d;
      end
   end

   assign over_range_out_a = out_a_q;
   assign over_range_out_b = out_b_q;
   assign over_range_or_clock_out_c = out_c_q;
   assign over_range_or_clock_out_d = out_d_q;
   assign pll_reference_clock_out = ref_out_q;
endmodule

`default_nettype wire

// ==== ocs_props.sv ====
// assertions on the over-range and clock-out ports of ocs_top
// assumes it is bound into ocs_top and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module ocs_props
#(
   parameter int NUM_CH = 4,
   parameter int MAG_W = 9,
   parameter int LEN_W = 8
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [MAG_W-1:0] magnitude_a,
   input wire logic [MAG_W-1:0] magnitude_b,
   input wire logic [MAG_W-1:0] magnitude_c,
   input wire logic [MAG_W-1:0] magnitude_d,
   input wire logic [MAG_W-1:0] over_range_threshold,
   input wire logic [LEN_W-1:0] over_range_min_pulse_len,
   input wire logic [1:0] aux_clock_select_pins,
   input wire logic clock_override_en,
   input wire logic [1:0] clock_override_sel_c,
   input wire logic clock_out_disable,
   input wire logic pll_enable_pin,
   input wire logic power_down_pin,
   input wire logic pll_ref_in,
   input wire logic over_range_out_a,
   input wire logic over_range_out_b,
   input wire logic over_range_or_clock_out_c,
   input wire logic over_range_or_clock_out_d,
   input wire logic pll_reference_clock_out
);
   // ==========
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic [1:0] sel;
   logic on;
   logic [MAG_W-1:0] thr;
   assign thr = over_range_threshold;
   assign sel = clock_override_en ? clock_override_sel_c : aux_clock_select_pins;
   assign on = (sel != 2'h0) && !clock_out_disable && pll_enable_pin && !power_down_pin;
   AST_A_RISE: assert property (magnitude_a > thr |-> ##2 over_range_out_a) else $error("flag a late");
   AST_A_HOLD: assert property (magnitude_a > thr && over_range_min_pulse_len >= 2 |-> ##3 over_range_out_a)
      else $error("flag a short");
   AST_A_FALL: assert property ($fell(over_range_out_a) |-> $past(magnitude_a, 2) <= $past(thr, 2))
      else $error("flag a fell early");
   AST_B_RISE: assert property (NUM_CH >= 2 && magnitude_b > thr |-> ##2 over_range_out_b) else $error("flag b");
   AST_C_FLAG: assert property (NUM_CH == 4 && magnitude_c > thr ##1 !on |=> over_range_or_clock_out_c)
      else $error("flag c");
   AST_D_FLAG: assert property (NUM_CH == 4 && magnitude_d > thr ##1 !on |=> over_range_or_clock_out_d)
      else $error("flag d");
   AST_C_COPY: assert property (!rst && on && sel == 2'h1
      |=> over_range_or_clock_out_c == $past(pll_ref_in)) else $error("clock c copy");
   AST_D_COPY: assert property (!rst && on && !clock_override_en
      |=> over_range_or_clock_out_d == $past(pll_ref_in)) else $error("clock d copy");
   AST_REF_PD: assert property (power_down_pin |=> !pll_reference_clock_out) else $error("ref out on");
   AST_REF_CP: assert property (!rst && pll_enable_pin && !power_down_pin
      |=> pll_reference_clock_out == $past(pll_ref_in)) else $error("ref out copy");
   cover property (on && sel == 2'h3);
   cover property ($fell(over_range_out_a));
   cover property (power_down_pin && pll_enable_pin);
endmodule
bind ocs_top ocs_props #(.NUM_CH(NUM_CH), .MAG_W(MAG_W), .LEN_W(LEN_W)) props_i (.*);
`default_nettype wire

// ==== ocs_partner.sv ====
// far-side monitor counting rising edges of the channel C and reference clock outputs
// assumes the receiving logic samples on clk_sys
`timescale 1ns/10ps
`default_nettype none
module ocs_partner
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_c,
   input wire logic clk_r,
   output logic [15:0] n_c,
   output logic [15:0] n_r
);
   logic c_q;
   logic r_q;
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         {c_q, r_q, n_c, n_r} <= '0;
      end
      else
      begin
         c_q <= clk_c;
         r_q <= clk_r;
         n_c <= n_c + 16'(clk_c & ~c_q);
         n_r <= n_r + 16'(clk_r & ~r_q);
      end
   end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for ocs_top
// assumes ocs_pkg, ocs_props and ocs_partner are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import ocs_pkg::*;
   // ==========
   // stimulus
   logic clk_sys = 1'b0, rst = 1'b1, ovr_en = 1'b0, dis = 1'b0, pll_en = 1'b1, pd = 1'b0, ref_in = 1'b0;
   logic [8:0] mag = 9'h000, thr = 9'h0ff;
   logic [7:0] len = 8'h00;
   logic [1:0] pins = 2'h0, osel = 2'h2;
   logic oa, ob, oc, od, orf;
   logic [15:0] n_c, n_r, dc, dr, e;
   logic [8:0] r_mag [4] = '{9'h100, 9'h0ff, 9'h1ff, 9'h000};
   logic [8:0] r_thr [4] = '{9'h0ff, 9'h0ff, 9'h000, 9'h000};
   logic r_exp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
   int err_total = 0, num_checks = 0, k;
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) ref_in <= ~ref_in;
   ocs_top uut (.clk_sys(clk_sys), .rst(rst), .magnitude_a(mag), .magnitude_b(mag), .magnitude_c(mag),
      .magnitude_d(mag), .over_range_threshold(thr), .over_range_min_pulse_len(len),
      .aux_clock_select_pins(pins), .clock_override_en(ovr_en), .clock_override_sel_c(osel),
      .clock_override_sel_d(osel), .clock_out_disable(dis), .pll_enable_pin(pll_en), .power_down_pin(pd),
      .pll_ref_in(ref_in), .over_range_out_a(oa), .over_range_out_b(ob), .over_range_or_clock_out_c(oc),
      .over_range_or_clock_out_d(od), .pll_reference_clock_out(orf));
   ocs_partner mon (.clk_sys(clk_sys), .rst(rst), .clk_c(oc), .clk_r(orf), .n_c(n_c), .n_r(n_r));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask
   task automatic meas;
      dc = n_c;
      dr = n_r;
      cyc(64);
      dc = n_c - dc;
      dr = n_r - dr;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      cyc(10);
      chk({oa, ob, oc, od, orf}, 16'h0000);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         mag <= r_mag[i];
         thr <= r_thr[i];
         cyc(3);
         chk({oa, ob, oc, od}, {4{r_exp[i]}});
      end
      $display("rows done");
      len <= 8'h03;
      thr <= 9'h0ff;
      mag <= 9'h1ff;
      cyc(1);
      mag <= 9'h000;
      k = 0;
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clk_sys);
         #1 k += oa;
      end
      chk(k[15:0], 16'h0003);
      $display("stretch done");
      cyc(1);
      for (int s = 1; s < 4; s++)
      begin
         pins <= s[1:0];
         cyc(4);
         meas();
         e = dr >> (s - 1);
         chk(16'(dc + 1 >= e && dc <= e + 1), 16'h0001);
      end
      $display("divider done");
      pd <= 1'b1;
      cyc(3);
      meas();
      chk(dc + dr, 16'h0000);
      pd <= 1'b0;
      ovr_en <= 1'b1;
      pins <= 2'h0;
      cyc(4);
      meas();
      e = dr >> 1;
      chk(16'(dc + 1 >= e && dc <= e + 1), 16'h0001);
      dis <= 1'b1;
      mag <= 9'h1ff;
      cyc(4);
      meas();
      chk({dc[14:0], oc}, 16'h0001);
      dis <= 1'b0;
      pll_en <= 1'b0;
      cyc(4);
      meas();
      chk({dr[14:0], oc}, 16'h0001);
      $display("override done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
